// file: tb/mms_switch_sva.sv
// Concurrent checks on the link between the core end and the memory map switch.
`timescale 1ns/100ps
`default_nettype none
module mms_switch_sva (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic mode_wr,
    input wire logic [4:0] mode_bits,
    input wire logic [2:0] req,
    input wire logic [2:0][23:0] addr,
    input wire logic [2:0] rvalid,
    input wire logic [2:0][2:0] region,
    input wire logic switch_cycle,
    input wire logic switch_pending,
    input wire logic [4:0] CFG_ACTIVE,
    input wire logic CONFLICT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_switch_delay;
        mode_wr ##1 (!mode_wr) [*2] |=> switch_cycle;
    endproperty
    a_switch_delay: assert property (p_switch_delay)
        else $error("switch cycle not three cycles after mode write");
    property p_no_early;
        mode_wr |=> !switch_cycle ##1 !switch_cycle;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("switch cycle came early");
    property p_cfg_update;
        mode_wr ##1 (!mode_wr) [*3] |=> CFG_ACTIVE == $past(mode_bits, 4);
    endproperty
    a_cfg_update: assert property (p_cfg_update)
        else $error("active map differs from written mode bits");
    property p_cfg_hold;
        !switch_cycle |=> $stable(CFG_ACTIVE);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("active map changed outside a switch cycle");
    property p_pending;
        mode_wr |=> switch_pending [*2];
    endproperty
    a_pending: assert property (p_pending)
        else $error("switch not pending after mode write");
    property p_hold_off;
        mode_wr |=> (req == 3'h0) [*3];
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("access issued before the switch completed");
    property p_rvalid;
        rvalid == $past(req);
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("answer not one cycle after request");
    property p_x_io;
        req[1] && addr[1] >= mms_pkg::X_IO_LO |=> region[1] == mms_pkg::RGN_IO;
    endproperty
    a_x_io: assert property (p_x_io)
        else $error("upper X window not decoded as peripheral");
    property p_y_io;
        req[2] |=> (region[2] == mms_pkg::RGN_IO) ==
            ($past(addr[2]) >= mms_pkg::Y_IO_LO && $past(addr[2]) <= mms_pkg::Y_IO_HI);
    endproperty
    a_y_io: assert property (p_y_io)
        else $error("Y peripheral window decoded wrongly");
    property p_no_conflict;
        !CONFLICT;
    endproperty
    a_no_conflict: assert property (p_no_conflict)
        else $error("access hit a remapped range in the switch cycle");
endmodule // mms_switch_sva
`default_nettype wire

// file: tb/tb_memory_map_switch.sv
// Self-checking bench for the memory map switch and its core end.
`timescale 1ns/100ps
`default_nettype none
module tb_memory_map_switch;
    localparam logic [1:0] SPP = mms_pkg::SP_P;
    localparam logic [1:0] SPX = mms_pkg::SP_X;
    localparam logic [1:0] SPY = mms_pkg::SP_Y;
    localparam logic [2:0] NON = mms_pkg::RGN_NONE;
    localparam logic [2:0] RAM = mms_pkg::RGN_RAM;
    localparam logic [2:0] ROM = mms_pkg::RGN_ROM;
    localparam logic [2:0] IO = mms_pkg::RGN_IO;
    logic CLK;
    logic RESET_N;
    logic [3:0] REG_ADDR;
    logic [31:0] REG_WDATA;
    logic REG_WR;
    logic REG_RD;
    logic [31:0] REG_RDATA;
    logic [4:0] CFG_ACTIVE;
    logic CONFLICT;
    logic [4:0] cur_mode;
    int mismatches;
    int n_compared;

    mms_if mms_if_inst ();
    mms_switch mms_switch_inst (.CLK(CLK), .RESET_N(RESET_N), .bus(mms_if_inst.dev),
        .CFG_ACTIVE(CFG_ACTIVE), .CONFLICT(CONFLICT));
    mms_core #(.CLKS_PER_INSTR(1)) mms_core_inst (.CLK(CLK), .RESET_N(RESET_N),
        .bus(mms_if_inst.core), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
    mms_switch_sva mms_switch_sva_inst (.CLK(CLK), .RESET_N(RESET_N),
        .mode_wr(mms_if_inst.mode_wr), .mode_bits(mms_if_inst.mode_bits),
        .req(mms_if_inst.req), .addr(mms_if_inst.addr), .rvalid(mms_if_inst.rvalid),
        .region(mms_if_inst.region), .switch_cycle(mms_if_inst.switch_cycle),
        .switch_pending(mms_if_inst.switch_pending), .CFG_ACTIVE(CFG_ACTIVE),
        .CONFLICT(CONFLICT));

    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Register port cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask

    // One guarded access; waits for the busy flag to drop under a bound.
    task automatic acc(input logic [1:0] sp, input logic [23:0] a, input logic w,
        input logic [23:0] wd, output logic [31:0] d, output logic [31:0] st);
        int n;
        wr(mms_pkg::REG_ACC_ADDR, {6'h00, sp, a});
        wr(mms_pkg::REG_ACC_WDATA, {8'h00, wd});
        wr(mms_pkg::REG_ACC_GO, {31'h0, w});
        n = 0;
        st = 32'h1;
        while (st[0] !== 1'b0 && n < 16) begin
            rd(mms_pkg::REG_STATUS, st);
            n++;
        end
        if (st[0] !== 1'b0) begin
            mismatches++;
            give_verdict();
        end
        rd(mms_pkg::REG_ACC_RDATA, d);
    endtask

    task automatic put(input logic [1:0] sp, input logic [23:0] a, input logic [23:0] wd);
        logic [31:0] d;
        logic [31:0] st;
        acc(sp, a, 1'b1, wd, d, st);
    endtask

    task automatic expect_acc(input logic [1:0] sp, input logic [23:0] a,
        input logic [23:0] ed, input logic [2:0] er);
        logic [31:0] d;
        logic [31:0] st;
        acc(sp, a, 1'b0, 24'h000000, d, st);
        chk("read data", {8'h00, ed}, {8'h00, d[23:0]});
        chk("region", {29'h0, er}, {29'h0, st[5:3]});
    endtask

    // Checks the old map up to the switch cycle and the new one right after it.
    task automatic set_mode(input logic [4:0] m);
        wr(mms_pkg::REG_MODE, {27'h0, m});
        repeat (2) @(posedge CLK);
        #1;
        chk("map before switch", {27'h0, cur_mode}, {27'h0, CFG_ACTIVE});
        @(posedge CLK);
        #1;
        chk("map after switch", {27'h0, m}, {27'h0, CFG_ACTIVE});
        cur_mode = m;
    endtask

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [31:0] st;
        RESET_N = 1'b0;
        REG_ADDR = 4'h0;
        REG_WDATA = 32'h0;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        mismatches = 0;
        n_compared = 0;
        cur_mode = 5'h00;
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(mms_pkg::REG_STATUS, st);
        chk("status at reset", 32'h0, st);
        chk("map at reset", 32'h0, {27'h0, CFG_ACTIVE});
        put(SPX, 24'h002000, 24'hA5A5A5);
        put(SPY, 24'h001400, 24'h5A5A5A);
        put(SPX, 24'h002C00, 24'h123456);
        put(SPX, 24'h003000, 24'h654321);
        put(SPP, 24'h000100, 24'h0F0F0F);
        expect_acc(SPX, 24'h002000, 24'hA5A5A5, RAM);
        set_mode(5'h02);
        expect_acc(SPP, 24'h000C00, 24'hA5A5A5, RAM);
        expect_acc(SPP, 24'h001C00, 24'h5A5A5A, RAM);
        expect_acc(SPP, 24'h002400, 24'h654321, RAM);
        expect_acc(SPP, 24'h000100, 24'h0F0F0F, RAM);
        expect_acc(SPX, 24'h002000, 24'h000000, NON);
        put(SPP, 24'h000C00, 24'h777777);
        set_mode(5'h06);
        expect_acc(SPY, 24'h001400, 24'h5A5A5A, RAM);
        expect_acc(SPP, 24'h001C00, 24'h000000, NON);
        set_mode(5'h0A);
        expect_acc(SPP, 24'h000C00, 24'h123456, RAM);
        set_mode(5'h00);
        expect_acc(SPX, 24'h002000, 24'h777777, RAM);
        expect_acc(SPP, 24'hFF1000, 24'h000000, ROM);
        expect_acc(SPP, 24'hFF0000, 24'h000000, mms_pkg::RGN_BOOT);
        expect_acc(SPX, 24'hFFFF80, 24'h000000, IO);
        expect_acc(SPX, 24'hFFFFFF, 24'h000000, IO);
        expect_acc(SPX, 24'hFFFF7F, 24'h000000, NON);
        expect_acc(SPY, 24'hFFFF80, 24'h000000, IO);
        expect_acc(SPY, 24'hFFFFAF, 24'h000000, IO);
        expect_acc(SPY, 24'hFFFFB0, 24'h000000, NON);
        expect_acc(SPY, 24'h005FFF, 24'h000000, ROM);
        expect_acc(SPY, 24'h006000, 24'h000000, NON);
        set_mode(5'h10);
        expect_acc(SPP, 24'hFF1000, 24'h000000, NON);
        expect_acc(SPP, 24'hFF0000, 24'h000000, NON);
        expect_acc(SPX, 24'h004000, 24'h000000, ROM);
        set_mode(5'h01);
        expect_acc(SPP, 24'h000BFF, 24'h000000, NON);
        for (int m = 0; m < 32; m++) begin
            set_mode(5'(m));
        end
        give_verdict();
    end
endmodule // tb_memory_map_switch
`default_nettype wire

// file: verilog/mms_core.sv
// Core-side end: instruction pacing, mode writes and guarded memory accesses.
`timescale 1ns/100ps
`default_nettype none
module mms_core #(
    parameter int CLKS_PER_INSTR = 1
) (
    input wire logic CLK,
    input wire logic RESET_N,
    mms_if.core bus,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RESP = 3'b100
    } mms_state_type;

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    mms_state_type st_ff;
    mms_state_type nxt_st;
    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    logic [1:0] hold_ff;
    logic [1:0] nxt_hold;
    logic [4:0] mode_ff;
    logic [4:0] nxt_mode;
    logic [25:0] acc_addr_ff;
    logic [25:0] nxt_acc_addr;
    logic [23:0] wdata_ff;
    logic [23:0] nxt_wdata;
    logic we_ff;
    logic nxt_we;
    logic [23:0] rdata_ff;
    logic [23:0] nxt_rdata;
    logic [2:0] region_ff;
    logic [2:0] nxt_region;
    logic [31:0] rd_ff;
    logic [31:0] nxt_rd;
    logic step;
    logic mode_wr;
    logic issue;
    logic [1:0] sp;

    always_comb begin
        nxt_st = st_ff;
        nxt_div = div_ff;
        nxt_hold = hold_ff;
        nxt_mode = mode_ff;
        nxt_acc_addr = acc_addr_ff;
        nxt_wdata = wdata_ff;
        nxt_we = we_ff;
        nxt_rdata = rdata_ff;
        nxt_region = region_ff;
        nxt_rd = rd_ff;
        sp = acc_addr_ff[25:24];
        step = div_ff == 8'(CLKS_PER_INSTR - 1);
        nxt_div = step ? 8'h00 : 8'(div_ff + 8'h01);
        mode_wr = REG_WR && REG_ADDR == mms_pkg::REG_MODE;
        // Accesses wait out the delay and the switch cycle itself.
        issue = st_ff == ST_WAIT && hold_ff == 2'h0 && !mode_wr;
        if (step && hold_ff != 2'h0) begin
            nxt_hold = 2'(hold_ff - 2'h1);
        end
        if (mode_wr) begin
            nxt_mode = REG_WDATA[4:0];
            nxt_hold = mms_pkg::SWITCH_DELAY;
        end
        if (REG_WR && REG_ADDR == mms_pkg::REG_ACC_ADDR && st_ff == ST_IDLE) begin
            nxt_acc_addr = REG_WDATA[25:0];
        end
        if (REG_WR && REG_ADDR == mms_pkg::REG_ACC_WDATA && st_ff == ST_IDLE) begin
            nxt_wdata = REG_WDATA[23:0];
        end
        unique case (st_ff)
            ST_IDLE: begin
                if (REG_WR && REG_ADDR == mms_pkg::REG_ACC_GO) begin
                    nxt_we = REG_WDATA[0];
                    nxt_st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (issue) begin
                    nxt_st = ST_RESP;
                end
            end
            ST_RESP: begin
                if (bus.rvalid[sp]) begin
                    nxt_rdata = bus.rdata[sp];
                    nxt_region = bus.region[sp];
                    nxt_st = ST_IDLE;
                end
            end
        endcase
        nxt_rd = 32'h00000000;
        if (REG_RD) begin
            unique case (REG_ADDR)
                mms_pkg::REG_MODE: nxt_rd = {27'h0000000, mode_ff};
                mms_pkg::REG_ACC_ADDR: nxt_rd = {6'h00, acc_addr_ff};
                mms_pkg::REG_ACC_WDATA: nxt_rd = {8'h00, wdata_ff};
                mms_pkg::REG_ACC_RDATA: nxt_rd = {8'h00, rdata_ff};
                mms_pkg::REG_STATUS: nxt_rd = {26'h0000000, region_ff,
                                               bus.switch_pending, hold_ff != 2'h0,
                                               st_ff != ST_IDLE};
                default: nxt_rd = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= ST_IDLE;
            div_ff <= 8'h00;
            hold_ff <= 2'h0;
            mode_ff <= mms_pkg::MODE_RESET;
            acc_addr_ff <= 26'h0000000;
            wdata_ff <= 24'h000000;
            we_ff <= 1'b0;
            rdata_ff <= 24'h000000;
            region_ff <= 3'h0;
            rd_ff <= 32'h00000000;
        end else begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            hold_ff <= nxt_hold;
            mode_ff <= nxt_mode;
            acc_addr_ff <= nxt_acc_addr;
            wdata_ff <= nxt_wdata;
            we_ff <= nxt_we;
            rdata_ff <= nxt_rdata;
            region_ff <= nxt_region;
            rd_ff <= nxt_rd;
        end
    end

    // ------------------------------------------------------------
    // Link drive
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            bus.req[i] = issue && sp == 2'(i);
            bus.we[i] = we_ff;
            bus.addr[i] = acc_addr_ff[23:0];
            bus.wdata[i] = wdata_ff;
        end
    end

    assign bus.instr_step = step;
    assign bus.mode_wr = mode_wr;
    assign bus.mode_bits = REG_WDATA[4:0];
    assign REG_RDATA = rd_ff;

endmodule // mms_core
`default_nettype wire

// file: verilog/mms_if.sv
// Connection between the processor core end and the memory map switch.
`timescale 1ns/100ps
`default_nettype none
interface mms_if;
    logic instr_step;
    logic mode_wr;
    logic [4:0] mode_bits;
    logic [2:0] req;
    logic [2:0] we;
    logic [2:0][23:0] addr;
    logic [2:0][23:0] wdata;
    logic [2:0] rvalid;
    logic [2:0][23:0] rdata;
    logic [2:0][2:0] region;
    logic switch_cycle;
    logic switch_pending;

    modport dev (
        input instr_step, mode_wr, mode_bits, req, we, addr, wdata,
        output rvalid, rdata, region, switch_cycle, switch_pending
    );
    modport core (
        output instr_step, mode_wr, mode_bits, req, we, addr, wdata,
        input rvalid, rdata, region, switch_cycle, switch_pending
    );
endinterface
`default_nettype wire

// file: verilog/mms_pkg.sv
// Constants, encodings and register map shared by both ends of the memory map switch.
package mms_pkg;

    // ------------------------------------------------------------
    // Widths and space indices
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 24;
    localparam int BLK_W = 10;
    localparam int PHYS_W = 5;
    localparam int RAM_BLOCKS = 23;
    localparam logic [1:0] SP_P = 2'h0;
    localparam logic [1:0] SP_X = 2'h1;
    localparam logic [1:0] SP_Y = 2'h2;

    // ------------------------------------------------------------
    // Mode bit positions and reset value
    // ------------------------------------------------------------
    localparam int MODE_W = 5;
    localparam int MB_CACHE_EN = 0;
    localparam int MB_RAM_SWAP_SELECT = 1;
    localparam int MB_SWAP_WIDTH_BIT0 = 2;
    localparam int MB_SWAP_WIDTH_BIT1 = 3;
    localparam int MB_SIXTEEN_BIT_COMPAT = 4;
    localparam logic [4:0] MODE_RESET = 5'h00;

    // ------------------------------------------------------------
    // Switch timing in instruction cycles
    // ------------------------------------------------------------
    localparam logic [1:0] SWITCH_DELAY = 2'h3;

    // ------------------------------------------------------------
    // Physical RAM block bases and per-mode sizes in 1K blocks
    // ------------------------------------------------------------
    localparam logic [4:0] Y_PHYS_BASE = 5'h0D;
    localparam logic [4:0] P_PHYS_BASE = 5'h14;
    localparam logic [4:0] X_BLKS_NORM = 5'h0D;
    localparam logic [4:0] X_BLKS_W10 = 5'h0B;
    localparam logic [4:0] X_BLKS_SWAP = 5'h08;
    localparam logic [4:0] Y_BLKS_NORM = 5'h07;
    localparam logic [4:0] Y_BLKS_SWAP = 5'h05;
    localparam logic [4:0] P_BLKS_NORM = 5'h03;
    localparam logic [4:0] P_BLKS_W00 = 5'h0A;
    localparam logic [4:0] P_BLKS_W01 = 5'h07;
    localparam logic [4:0] P_BLKS_W10 = 5'h04;
    localparam logic [4:0] P_HIGH_BLK = 5'h09;

    // ------------------------------------------------------------
    // ROM and peripheral windows
    // ------------------------------------------------------------
    localparam logic [23:0] X_IO_LO = 24'hFFFF80;
    localparam logic [23:0] Y_IO_LO = 24'hFFFF80;
    localparam logic [23:0] Y_IO_HI = 24'hFFFFAF;
    localparam logic [23:0] DROM_LO = 24'h004000;
    localparam logic [23:0] XROM_HI = 24'h00BFFF;
    localparam logic [23:0] YROM_HI = 24'h005FFF;
    localparam logic [23:0] PROM_LO = 24'hFF1000;
    localparam logic [23:0] PROM_HI = 24'hFFAFFF;
    localparam logic [23:0] BOOT_LO = 24'hFF0000;
    localparam logic [23:0] BOOT_HI = 24'hFF00BF;

    // ------------------------------------------------------------
    // Region codes reported per access
    // ------------------------------------------------------------
    localparam logic [2:0] RGN_NONE = 3'h0;
    localparam logic [2:0] RGN_RAM = 3'h1;
    localparam logic [2:0] RGN_ROM = 3'h2;
    localparam logic [2:0] RGN_BOOT = 3'h3;
    localparam logic [2:0] RGN_IO = 3'h4;

    // ------------------------------------------------------------
    // Core-side command registers
    // ------------------------------------------------------------
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_ACC_ADDR = 4'h1;
    localparam logic [3:0] REG_ACC_WDATA = 4'h2;
    localparam logic [3:0] REG_ACC_GO = 4'h3;
    localparam logic [3:0] REG_ACC_RDATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam int ACC_SPACE_LSB = 24;

endpackage

// file: verilog/mms_switch.sv
// Memory map switch: shadow configuration, delayed switch and RAM routing.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module mms_switch (
    input wire logic CLK,
    input wire logic RESET_N,
    mms_if.dev bus,
    output logic [4:0] CFG_ACTIVE,
    output logic CONFLICT
);

    // ------------------------------------------------------------
    // Routing table
    // ------------------------------------------------------------

    // Returns {valid, physical block} for one space and address.
    function automatic logic [5:0] map_blk(input logic [1:0] sp, input logic [23:0] a,
                                          input logic [4:0] c);
        logic ms;
        logic ce;
        logic w10;
        logic w01;
        logic [4:0] k;
        logic [4:0] lim;
        logic ok;
        logic [4:0] ph;
        ms = c[mms_pkg::MB_RAM_SWAP_SELECT];
        ce = c[mms_pkg::MB_CACHE_EN];
        w10 = c[mms_pkg::MB_SWAP_WIDTH_BIT1] & ~c[mms_pkg::MB_SWAP_WIDTH_BIT0];
        w01 = c[mms_pkg::MB_SWAP_WIDTH_BIT0] & ~c[mms_pkg::MB_SWAP_WIDTH_BIT1];
        k = a[14:10];
        ok = 1'b0;
        ph = k;
        if (a[23:15] == 9'h000) begin
            if (sp == mms_pkg::SP_X) begin
                lim = !ms ? mms_pkg::X_BLKS_NORM : (w10 ? mms_pkg::X_BLKS_W10
                                                        : mms_pkg::X_BLKS_SWAP);
                ok = k < lim;
                ph = k;
            end else if (sp == mms_pkg::SP_Y) begin
                lim = (!ms || w10 || w01) ? mms_pkg::Y_BLKS_NORM : mms_pkg::Y_BLKS_SWAP;
                ok = k < lim;
                ph = 5'(mms_pkg::Y_PHYS_BASE + k);
            end else if (!ms) begin
                lim = 5'(mms_pkg::P_BLKS_NORM - {4'h0, ce});
                ok = k < lim;
                ph = 5'(mms_pkg::P_PHYS_BASE + k);
            end else begin
                lim = w10 ? mms_pkg::P_BLKS_W10 : (w01 ? mms_pkg::P_BLKS_W01
                                                       : mms_pkg::P_BLKS_W00);
                ok = (k < lim && !(k == mms_pkg::P_HIGH_BLK && ce))
                     || (k == mms_pkg::P_HIGH_BLK && !ce && (w10 || w01));
                if (k < 5'h03) begin
                    ph = 5'(mms_pkg::P_PHYS_BASE + k);
                end else if (k == 5'h03) begin
                    ph = w10 ? 5'h0B : 5'h08;
                end else if (k < 5'h07) begin
                    ph = 5'(k + 5'h05);
                end else if (k == 5'h07) begin
                    ph = 5'h12;
                end else if (k == 5'h08) begin
                    ph = 5'h13;
                end else begin
                    ph = 5'h0C;
                end
            end
        end
        return {ok, ph};
    endfunction

    // Classifies an address into RAM, ROM, boot ROM, peripheral window or nothing.
    function automatic logic [2:0] classify(input logic [1:0] sp, input logic [23:0] a,
                                            input logic [4:0] c);
        logic [5:0] m;
        logic sc;
        logic [2:0] r;
        m = map_blk(sp, a, c);
        sc = c[mms_pkg::MB_SIXTEEN_BIT_COMPAT];
        r = mms_pkg::RGN_NONE;
        if (m[5]) begin
            r = mms_pkg::RGN_RAM;
        end else if (sp == mms_pkg::SP_X) begin
            if (a >= mms_pkg::X_IO_LO) begin
                r = mms_pkg::RGN_IO;
            end else if (a >= mms_pkg::DROM_LO && a <= mms_pkg::XROM_HI) begin
                r = mms_pkg::RGN_ROM;
            end
        end else if (sp == mms_pkg::SP_Y) begin
            if (a >= mms_pkg::Y_IO_LO && a <= mms_pkg::Y_IO_HI) begin
                r = mms_pkg::RGN_IO;
            end else if (a >= mms_pkg::DROM_LO && a <= mms_pkg::YROM_HI) begin
                r = mms_pkg::RGN_ROM;
            end
        end else if (!sc) begin
            if (a >= mms_pkg::PROM_LO && a <= mms_pkg::PROM_HI) begin
                r = mms_pkg::RGN_ROM;
            end else if (a >= mms_pkg::BOOT_LO && a <= mms_pkg::BOOT_HI) begin
                r = mms_pkg::RGN_BOOT;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Switch control state
    // ------------------------------------------------------------
    logic [4:0] cfg_ff;
    logic [4:0] nxt_cfg;
    logic [4:0] staged_ff;
    logic [4:0] nxt_staged;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic conflict_ff;
    logic nxt_conflict;
    logic switch_now;

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_staged = staged_ff;
        nxt_cnt = cnt_ff;
        switch_now = bus.instr_step && cnt_ff == 2'h1;
        nxt_conflict = 1'b0;
        if (bus.instr_step && cnt_ff != 2'h0) begin
            nxt_cnt = 2'(cnt_ff - 2'h1);
        end
        if (switch_now) begin
            nxt_cfg = staged_ff;
        end
        if (bus.mode_wr) begin
            nxt_staged = bus.mode_bits;
            nxt_cnt = mms_pkg::SWITCH_DELAY;
        end
        for (int i = 0; i < 3; i++) begin
            if (switch_now && bus.req[i]
                && map_blk(2'(i), bus.addr[i], cfg_ff) != map_blk(2'(i), bus.addr[i],
                                                                   staged_ff)) begin
                nxt_conflict = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_ff <= mms_pkg::MODE_RESET;
            staged_ff <= mms_pkg::MODE_RESET;
            cnt_ff <= 2'h0;
            conflict_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            staged_ff <= nxt_staged;
            cnt_ff <= nxt_cnt;
            conflict_ff <= nxt_conflict;
        end
    end

    // ------------------------------------------------------------
    // Physical RAM and access paths
    // ------------------------------------------------------------
    logic [23:0] ram [0:mms_pkg::RAM_BLOCKS * 1024 - 1];
    logic [2:0] hit;
    logic [2:0][14:0] phys_addr;
    logic [2:0][5:0] cur_map;
    logic [2:0][2:0] nxt_region;
    logic [2:0] rvalid_ff;
    logic [2:0][23:0] rdata_ff;
    logic [2:0][2:0] region_ff;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_region[i] = classify(2'(i), bus.addr[i], cfg_ff);
            hit[i] = bus.req[i] && nxt_region[i] == mms_pkg::RGN_RAM;
            cur_map[i] = map_blk(2'(i), bus.addr[i], cfg_ff);
            phys_addr[i] = {cur_map[i][4:0], bus.addr[i][mms_pkg::BLK_W-1:0]};
        end
    end

    // Contents live in physical blocks, so a remap never touches them.
    always_ff @(posedge CLK) begin
        for (int i = 0; i < 3; i++) begin
            if (hit[i] && bus.we[i]) begin
                ram[phys_addr[i]] <= bus.wdata[i];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rvalid_ff <= 3'h0;
            rdata_ff <= '0;
            region_ff <= '0;
        end else begin
            rvalid_ff <= bus.req;
            for (int i = 0; i < 3; i++) begin
                if (bus.req[i]) begin
                    region_ff[i] <= nxt_region[i];
                    rdata_ff[i] <= (hit[i] && !bus.we[i]) ? ram[phys_addr[i]] : 24'h000000;
                end
            end
        end
    end

    assign bus.rvalid = rvalid_ff;
    assign bus.rdata = rdata_ff;
    assign bus.region = region_ff;
    assign bus.switch_cycle = switch_now;
    assign bus.switch_pending = cnt_ff != 2'h0;
    assign CFG_ACTIVE = cfg_ff;
    assign CONFLICT = conflict_ff;

endmodule // mms_switch
`default_nettype wire
